/* File: common/iomd_pkg.sv */
// Notes on behaviour
// - Internal registers decode on address bits 7:0 only; bits 15:8 are ignored.
// - 00H-07H select the memory manager: boundary/base and base for four windows.
// - 20H-27H select four timers: even is counter, odd is control or status.
// - 28H is shared baud; 2AH/2CH data, 2BH/2DH mode, command or status.
// - 30H-33H select two clocked serial channels: even data, odd command or status.
// - 38H-3FH select four ports; odd is direction, 39H is bit command.
// - Without DRAM, lower half is external area 0, upper half external area 1.
// - With DRAM, 80000H-BFFFFH is DRAM, C0000H-FFFFFH external area 1.
// - DRAM accesses always take three system clocks, whatever the area 1 wait.
// - The highest DRAM bank may be mapped over external area 1.
// - DRAM area holds one, four or sixteen banks, never more than sixteen.
// - Area 0 has no wait only with control bits 5 and 4 both set; area 1 has none whenever bit 5 is set.
// - System clock is the input clock divided by two on chip.
// - Control bits 7:6 give one to four external I/O waits, three to six clocks.
// - With four I/O waits the I/O strobe starts half a clock later.
package iomd_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_INT   = 4'b0010,
        ST_EXTIO = 4'b0100,
        ST_MEM   = 4'b1000
    } iomd_state_t;

    typedef struct packed {
        logic [7:0] blk;
        logic [2:0] idx;
        logic       func;
        logic       special;
    } iomd_io_sel_t;

    typedef struct packed {
        logic       ext0;
        logic       ext1;
        logic       dram;
        logic [3:0] bank;
    } iomd_area_t;

    // One-hot peripheral groups
    localparam logic [7:0] BLK_NONE = 8'h00;
    localparam logic [7:0] BLK_MMU  = 8'h01;
    localparam logic [7:0] BLK_DMA  = 8'h02;
    localparam logic [7:0] BLK_SCR  = 8'h04;
    localparam logic [7:0] BLK_TMR  = 8'h08;
    localparam logic [7:0] BLK_UART = 8'h10;
    localparam logic [7:0] BLK_CSIO = 8'h20;
    localparam logic [7:0] BLK_INTC = 8'h40;
    localparam logic [7:0] BLK_PORT = 8'h80;

    // Internal I/O addresses
    localparam logic [7:0] A_MMU_LO   = 8'h00;
    localparam logic [7:0] A_MMU_HI   = 8'h07;
    localparam logic [7:0] A_DMA_LO   = 8'h10;
    localparam logic [7:0] A_DMA_HI   = 8'h17;
    localparam logic [7:0] A_SCR_LO   = 8'h1b;
    localparam logic [7:0] A_SCR_HI   = 8'h1f;
    localparam logic [7:0] A_TMR_LO   = 8'h20;
    localparam logic [7:0] A_TMR_HI   = 8'h27;
    localparam logic [7:0] A_BAUD     = 8'h28;
    localparam logic [7:0] A_UART_LO  = 8'h2a;
    localparam logic [7:0] A_UART_HI  = 8'h2d;
    localparam logic [7:0] A_CSIO_LO  = 8'h30;
    localparam logic [7:0] A_CSIO_HI  = 8'h33;
    localparam logic [7:0] A_INTC_LO  = 8'h34;
    localparam logic [7:0] A_INTC_HI  = 8'h37;
    localparam logic [7:0] A_PORT_LO  = 8'h38;
    localparam logic [7:0] A_PORT_BIT = 8'h39;
    localparam logic [7:0] A_PORT_HI  = 8'h3f;
    localparam logic [7:0] A_INT_END  = 8'h40;
    localparam logic [2:0] SCR_FIRST  = 3'h3;
    localparam logic [2:0] IDX_BAUD   = 3'h4;

    // Memory areas
    localparam logic [1:0] HALF_DRAM  = 2'h2;
    localparam logic [1:0] HALF_TOP   = 2'h3;
    localparam logic [1:0] BANKS_1    = 2'h0;
    localparam logic [1:0] BANKS_4    = 2'h1;
    localparam logic [3:0] TOP_BANK_1 = 4'h0;
    localparam logic [3:0] TOP_BANK_4 = 4'h3;
    localparam logic [3:0] TOP_BANK16 = 4'hf;

    // Timing: cycle lengths in system clocks, strobe starts in input clocks
    localparam logic [3:0] MCLK_PER_SYS   = 4'h2;
    localparam logic [3:0] INT_SYS_CLKS   = 4'h1;
    localparam logic [3:0] DRAM_SYS_CLKS  = 4'h3;
    localparam logic [3:0] MEM_BASE_CLKS  = 4'h2;
    localparam logic [3:0] IO_BASE_CLKS   = 4'h3;
    localparam logic [3:0] STB_START      = 4'h1;
    localparam logic [3:0] STB_START_SLOW = 4'h2;
    localparam logic [1:0] IO_WAIT_MAX    = 2'h3;

    // Reset values and constants
    localparam logic [7:0] RSV_RDATA  = 8'hff;
    localparam logic       SYSCLK_RST = 1'b0;

endpackage

/* File: logic/iomd_clkdiv.sv */
`timescale 1ns/1ps
module iomd_clkdiv
    import iomd_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    output logic      sys_clk
);
    logic next_sys_clk;

    always_comb begin
        next_sys_clk = ~sys_clk;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sys_clk <= SYSCLK_RST;
        end else begin
            sys_clk <= next_sys_clk;
        end
    end
endmodule

/* File: logic/iomd_decoder.sv */
`timescale 1ns/1ps
module iomd_decoder
    import iomd_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        io_req,
    input  wire logic        io_wr,
    input  wire logic [15:0] io_addr,
    input  wire logic        mem_req,
    input  wire logic        mem_wr,
    input  wire logic [19:0] mem_addr,
    input  wire logic [7:0]  system_control_0,
    input  wire logic        dram_en,
    input  wire logic        dram_top_remap,
    input  wire logic [1:0]  dram_bank_cfg,
    output logic             sys_clk,
    output logic             busy,
    output logic             done,
    output iomd_io_sel_t     int_sel,
    output logic             int_rd,
    output logic             int_wr,
    output logic             rsv_hit,
    output logic [7:0]       rsv_rdata,
    output logic             ext_io_rd_n,
    output logic             ext_io_wr_n,
    output iomd_area_t       mem_area,
    output logic             ext_mem_rd_n,
    output logic             ext_mem_wr_n
);
    iomd_state_t  state;
    iomd_state_t  next_state;
    logic [3:0]   cnt;
    logic [3:0]   next_cnt;
    logic [3:0]   len;
    logic [3:0]   next_len;
    logic [3:0]   stb_start;
    logic [3:0]   next_stb_start;
    logic         wr;
    logic         next_wr;
    logic         next_busy;
    logic         next_done;
    iomd_io_sel_t next_int_sel;
    logic         next_int_rd;
    logic         next_int_wr;
    logic         next_rsv_hit;
    logic         next_ext_io_rd_n;
    logic         next_ext_io_wr_n;
    iomd_area_t   next_mem_area;
    logic         next_ext_mem_rd_n;
    logic         next_ext_mem_wr_n;
    iomd_io_sel_t dec;
    iomd_area_t   area;
    logic         accept;
    logic         is_int;
    logic [3:0]   mem_clks;
    logic         stb_on;

    iomd_clkdiv u_clkdiv (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .sys_clk (sys_clk)
    );

    // Internal I/O decode on the low byte
    always_comb begin
        logic [7:0] a;
        a   = io_addr[7:0];
        dec = '{blk: BLK_NONE, idx: 3'h0, func: 1'b0, special: 1'b0};
        if (a <= A_MMU_HI) begin
            dec = '{blk: BLK_MMU, idx: {1'b0, a[2:1]}, func: a[0], special: 1'b0};
        end else if (a >= A_DMA_LO && a <= A_DMA_HI) begin
            dec = '{blk: BLK_DMA, idx: a[2:0], func: 1'b0, special: 1'b0};
        end else if (a >= A_SCR_LO && a <= A_SCR_HI) begin
            dec = '{blk: BLK_SCR, idx: a[2:0] - SCR_FIRST, func: 1'b0, special: 1'b0};
        end else if (a >= A_TMR_LO && a <= A_TMR_HI) begin
            dec = '{blk: BLK_TMR, idx: {1'b0, a[2:1]}, func: a[0], special: 1'b0};
        end else if (a == A_BAUD) begin
            dec = '{blk: BLK_UART, idx: IDX_BAUD, func: 1'b0, special: 1'b0};
        end else if (a >= A_UART_LO && a <= A_UART_HI) begin
            dec = '{blk: BLK_UART, idx: {2'h0, a[2]}, func: a[0], special: 1'b0};
        end else if (a >= A_CSIO_LO && a <= A_CSIO_HI) begin
            dec = '{blk: BLK_CSIO, idx: {2'h0, a[1]}, func: a[0], special: 1'b0};
        end else if (a >= A_INTC_LO && a <= A_INTC_HI) begin
            dec = '{blk: BLK_INTC, idx: {1'b0, a[1:0]}, func: 1'b0, special: 1'b0};
        end else if (a >= A_PORT_LO && a <= A_PORT_HI) begin
            dec = '{blk: BLK_PORT, idx: {1'b0, a[2:1]}, func: a[0],
                    special: (a == A_PORT_BIT)};
        end
    end

    // Memory area and bank decode
    always_comb begin
        area     = '{ext0: 1'b0, ext1: 1'b0, dram: 1'b0, bank: 4'h0};
        mem_clks = MEM_BASE_CLKS + {3'h0, ~system_control_0[5]};
        if (!mem_addr[19]) begin
            area.ext0 = 1'b1;
            mem_clks  = MEM_BASE_CLKS + {3'h0, ~(system_control_0[5] & system_control_0[4])};
        end else if (!dram_en) begin
            area.ext1 = 1'b1;
        end else if (mem_addr[19:18] == HALF_DRAM) begin
            area.dram = 1'b1;
            mem_clks  = DRAM_SYS_CLKS;
            case (dram_bank_cfg)
                BANKS_1: area.bank = 4'h0;
                BANKS_4: area.bank = {2'h0, mem_addr[17:16]};
                default: area.bank = mem_addr[17:14];
            endcase
        end else if (dram_top_remap) begin
            area.dram = 1'b1;
            mem_clks  = DRAM_SYS_CLKS;
            case (dram_bank_cfg)
                BANKS_1: area.bank = TOP_BANK_1;
                BANKS_4: area.bank = TOP_BANK_4;
                default: area.bank = TOP_BANK16;
            endcase
        end else begin
            area.ext1 = 1'b1;
        end
    end

    assign accept = (state == ST_IDLE) && !sys_clk && (io_req || mem_req);
    assign is_int = io_addr[7:0] < A_INT_END;
    assign stb_on = (next_cnt >= stb_start) && (next_cnt < len - 4'h1);

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_len       = len;
        next_stb_start = stb_start;
        next_wr        = wr;
        next_int_sel   = int_sel;
        next_rsv_hit   = rsv_hit;
        next_mem_area  = mem_area;
        next_done      = 1'b0;
        case (state)
            ST_IDLE: begin
                next_cnt = 4'h0;
                if (accept && io_req) begin
                    next_wr        = io_wr;
                    next_stb_start = STB_START;
                    if (is_int) begin
                        next_state   = ST_INT;
                        next_len     = INT_SYS_CLKS * MCLK_PER_SYS;
                        next_int_sel = dec;
                        next_rsv_hit = (dec.blk == BLK_NONE);
                    end else begin
                        next_state = ST_EXTIO;
                        next_len   = (IO_BASE_CLKS + {2'h0, system_control_0[7:6]})
                                     * MCLK_PER_SYS;
                        if (system_control_0[7:6] == IO_WAIT_MAX) begin
                            next_stb_start = STB_START_SLOW;
                        end
                    end
                end else if (accept) begin
                    next_state     = ST_MEM;
                    next_wr        = mem_wr;
                    next_len       = mem_clks * MCLK_PER_SYS;
                    next_stb_start = STB_START;
                    next_mem_area  = area;
                end
            end
            ST_INT, ST_EXTIO, ST_MEM: begin
                if (cnt == len - 4'h1) begin
                    next_state    = ST_IDLE;
                    next_cnt      = 4'h0;
                    next_done     = 1'b1;
                    next_int_sel  = '{blk: BLK_NONE, idx: 3'h0, func: 1'b0, special: 1'b0};
                    next_rsv_hit  = 1'b0;
                    next_mem_area = '{ext0: 1'b0, ext1: 1'b0, dram: 1'b0, bank: 4'h0};
                end else begin
                    next_cnt = cnt + 4'h1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt   = 4'h0;
            end
        endcase
        next_busy         = (next_state != ST_IDLE);
        next_int_rd       = (next_state == ST_INT) && !next_wr && !next_rsv_hit;
        next_int_wr       = (next_state == ST_INT) && next_wr && !next_rsv_hit;
        next_ext_io_rd_n  = !((next_state == ST_EXTIO) && !next_wr && stb_on);
        next_ext_io_wr_n  = !((next_state == ST_EXTIO) && next_wr && stb_on);
        next_ext_mem_rd_n = !((next_state == ST_MEM) && !next_mem_area.dram && !next_wr && stb_on);
        next_ext_mem_wr_n = !((next_state == ST_MEM) && !next_mem_area.dram && next_wr && stb_on);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= ST_IDLE;
            cnt          <= 4'h0;
            len          <= 4'h0;
            stb_start    <= STB_START;
            wr           <= 1'b0;
            busy         <= 1'b0;
            done         <= 1'b0;
            int_sel      <= '{blk: BLK_NONE, idx: 3'h0, func: 1'b0, special: 1'b0};
            int_rd       <= 1'b0;
            int_wr       <= 1'b0;
            rsv_hit      <= 1'b0;
            rsv_rdata    <= RSV_RDATA;
            ext_io_rd_n  <= 1'b1;
            ext_io_wr_n  <= 1'b1;
            mem_area     <= '{ext0: 1'b0, ext1: 1'b0, dram: 1'b0, bank: 4'h0};
            ext_mem_rd_n <= 1'b1;
            ext_mem_wr_n <= 1'b1;
        end else begin
            state        <= next_state;
            cnt          <= next_cnt;
            len          <= next_len;
            stb_start    <= next_stb_start;
            wr           <= next_wr;
            busy         <= next_busy;
            done         <= next_done;
            int_sel      <= next_int_sel;
            int_rd       <= next_int_rd;
            int_wr       <= next_int_wr;
            rsv_hit      <= next_rsv_hit;
            rsv_rdata    <= RSV_RDATA;
            ext_io_rd_n  <= next_ext_io_rd_n;
            ext_io_wr_n  <= next_ext_io_wr_n;
            mem_area     <= next_mem_area;
            ext_mem_rd_n <= next_ext_mem_rd_n;
            ext_mem_wr_n <= next_ext_mem_wr_n;
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic io_acc;
    logic mem_acc;
    assign io_acc  = accept && io_req;
    assign mem_acc = accept && !io_req;

    sequence s_dram_cycle;
        busy [*6] ##1 (done && !busy);
    endsequence
    sequence s_zero_wait_cycle;
        busy [*4] ##1 (done && !busy);
    endsequence

    property p_upper_ignored;
        io_acc && is_int |=> state == ST_INT && int_sel.idx == $past(dec.idx);
    endproperty
    a_upper_ignored: assert property (p_upper_ignored) else $error("high byte changed decode");

    property p_mmu;
        io_acc && io_addr[7:0] <= A_MMU_HI
            |=> int_sel.blk == BLK_MMU && int_sel.func == $past(io_addr[0]);
    endproperty
    a_mmu: assert property (p_mmu) else $error("memory manager not selected");

    property p_timer;
        io_acc && io_addr[7:3] == A_TMR_LO[7:3]
            |=> int_sel.blk == BLK_TMR && int_sel.idx[1:0] == $past(io_addr[2:1]);
    endproperty
    a_timer: assert property (p_timer) else $error("timer channel wrong");

    property p_port_bit;
        io_acc && io_addr[7:0] == A_PORT_BIT |=> int_sel.blk == BLK_PORT && int_sel.special;
    endproperty
    a_port_bit: assert property (p_port_bit) else $error("bit command not flagged");

    property p_reserved;
        io_acc && is_int && dec.blk == BLK_NONE
            |=> (rsv_hit && !int_rd && !int_wr && rsv_rdata == RSV_RDATA) [*2];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved address selected");

    property p_no_dram_map;
        mem_acc && !dram_en |=> mem_area.ext0 != mem_area.ext1 && !mem_area.dram
            && mem_area.ext1 == $past(mem_addr[19]);
    endproperty
    a_no_dram_map: assert property (p_no_dram_map) else $error("area wrong without dram");

    property p_dram_time;
        mem_acc && dram_en && mem_addr[19:18] == HALF_DRAM |=> mem_area.dram ##0 s_dram_cycle;
    endproperty
    a_dram_time: assert property (p_dram_time) else $error("dram cycle not three clocks");

    property p_bank16;
        mem_acc && dram_en && mem_addr[19:18] == HALF_DRAM && dram_bank_cfg == 2'h2
            |=> mem_area.bank == $past(mem_addr[17:14]);
    endproperty
    a_bank16: assert property (p_bank16) else $error("bank number wrong");

    property p_remap;
        mem_acc && dram_en && dram_top_remap && mem_addr[19:18] == HALF_TOP
            |=> mem_area.dram && !mem_area.ext1
                && (mem_area.bank != 4'h0 || $past(dram_bank_cfg) == BANKS_1);
    endproperty
    a_remap: assert property (p_remap) else $error("top bank not mapped");

    property p_area0_fast;
        mem_acc && !mem_addr[19] && system_control_0[5:4] == 2'h3 |=> s_zero_wait_cycle;
    endproperty
    a_area0_fast: assert property (p_area0_fast) else $error("area 0 wait wrong");

    property p_io_six;
        io_acc && !is_int && system_control_0[7:6] == 2'h3 |-> ##12 busy ##1 (done && !busy);
    endproperty
    a_io_six: assert property (p_io_six) else $error("io cycle not six clocks");

    property p_io_late;
        io_acc && !is_int && !io_wr && system_control_0[7:6] == 2'h3
            |=> ext_io_rd_n [*2] ##1 !ext_io_rd_n;
    endproperty
    a_io_late: assert property (p_io_late) else $error("strobe not delayed");

    property p_sys_half;
        sys_clk |=> !sys_clk ##1 sys_clk;
    endproperty
    a_sys_half: assert property (p_sys_half) else $error("system clock not halved");
endmodule

/* File: sim/iomd_cpu_model.sv */
`timescale 1ns/1ps
module iomd_cpu_model
    import iomd_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         busy,
    input  wire logic         done,
    input  wire iomd_io_sel_t int_sel,
    input  wire logic         int_rd,
    input  wire logic         int_wr,
    input  wire logic         rsv_hit,
    input  wire iomd_area_t   mem_area,
    input  wire logic         ext_io_rd_n,
    input  wire logic         ext_io_wr_n,
    input  wire logic         ext_mem_rd_n,
    input  wire logic         ext_mem_wr_n,
    output logic              io_req,
    output logic              io_wr,
    output logic [15:0]       io_addr,
    output logic              mem_req,
    output logic              mem_wr,
    output logic [19:0]       mem_addr
);
    initial begin
        io_req   = 1'b0;
        io_wr    = 1'b0;
        io_addr  = 16'h0000;
        mem_req  = 1'b0;
        mem_wr   = 1'b0;
        mem_addr = 20'h00000;
    end

    // One cycle: request held until busy, then measured until done
    task automatic run(input logic is_io, input logic wr, input logic [19:0] addr,
                       output int nbusy, output int first, output logic [3:0] lows,
                       output iomd_io_sel_t sel, output iomd_area_t area,
                       output logic [2:0] flags, output logic ok);
        int         k;
        logic [3:0] strb;
        nbusy = 0;
        first = -1;
        lows  = 4'h0;
        ok    = 1'b0;
        @(posedge mclk);
        io_req   <= is_io;
        mem_req  <= !is_io;
        io_wr    <= wr;
        mem_wr   <= wr;
        io_addr  <= addr[15:0];
        mem_addr <= addr;
        for (k = 0; k < 20 && busy !== 1'b1; k++) @(posedge mclk);
        io_req   <= 1'b0;
        mem_req  <= 1'b0;
        io_addr  <= ~addr[15:0];
        mem_addr <= ~addr;
        sel   = int_sel;
        area  = mem_area;
        flags = {int_rd, int_wr, rsv_hit};
        while (busy === 1'b1 && nbusy < 20) begin
            strb = {ext_io_rd_n, ext_io_wr_n, ext_mem_rd_n, ext_mem_wr_n};
            if (strb !== 4'hf && first < 0) first = nbusy;
            lows = lows | ~strb;
            nbusy++;
            @(posedge mclk);
        end
        ok = (done === 1'b1);
    endtask
endmodule

/* File: sim/io_and_memory_address_decoder_test.sv */
`timescale 1ns/1ps
module io_and_memory_address_decoder_test
    import iomd_pkg::*;
;
    logic         mclk, rst_n, io_req, io_wr, mem_req, mem_wr;
    logic [15:0]  io_addr;
    logic [19:0]  mem_addr;
    logic [7:0]   system_control_0, rsv_rdata;
    logic         dram_en, dram_top_remap, sys_clk, busy, done, int_rd, int_wr, rsv_hit;
    logic [1:0]   dram_bank_cfg;
    logic         ext_io_rd_n, ext_io_wr_n, ext_mem_rd_n, ext_mem_wr_n;
    iomd_io_sel_t int_sel, sel;
    iomd_area_t   mem_area, area;
    int           n_errors, n_compared, n_busy, first_low;
    logic [3:0]   low_mask;
    logic [2:0]   flags;

    iomd_decoder u_dut (.mclk(mclk), .rst_n(rst_n), .io_req(io_req), .io_wr(io_wr),
        .io_addr(io_addr), .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .system_control_0(system_control_0), .dram_en(dram_en),
        .dram_top_remap(dram_top_remap), .dram_bank_cfg(dram_bank_cfg), .sys_clk(sys_clk),
        .busy(busy), .done(done), .int_sel(int_sel), .int_rd(int_rd), .int_wr(int_wr),
        .rsv_hit(rsv_hit), .rsv_rdata(rsv_rdata), .ext_io_rd_n(ext_io_rd_n),
        .ext_io_wr_n(ext_io_wr_n), .mem_area(mem_area), .ext_mem_rd_n(ext_mem_rd_n),
        .ext_mem_wr_n(ext_mem_wr_n));

    iomd_cpu_model u_cpu (.mclk(mclk), .busy(busy), .done(done), .int_sel(int_sel),
        .int_rd(int_rd), .int_wr(int_wr), .rsv_hit(rsv_hit), .mem_area(mem_area),
        .ext_io_rd_n(ext_io_rd_n), .ext_io_wr_n(ext_io_wr_n), .ext_mem_rd_n(ext_mem_rd_n),
        .ext_mem_wr_n(ext_mem_wr_n), .io_req(io_req), .io_wr(io_wr), .io_addr(io_addr),
        .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cfg(input logic [7:0] sc, input logic en, input logic rm, input logic [1:0] bk);
        @(posedge mclk);
        system_control_0 <= sc;
        dram_en          <= en;
        dram_top_remap   <= rm;
        dram_bank_cfg    <= bk;
    endtask

    task automatic xfer(input logic is_io, input logic wr, input logic [19:0] addr);
        logic ok;
        u_cpu.run(is_io, wr, addr, n_busy, first_low, low_mask, sel, area, flags, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            $display("ERROR cycle expected done seen none");
            stop_test();
        end
    endtask

    task automatic t_reset();
        logic prev;
        @(posedge mclk);
        chk("busy", busy, 1'b0);
        chk("rsv_rdata", rsv_rdata, RSV_RDATA);
        chk("strobes", {ext_io_rd_n, ext_io_wr_n, ext_mem_rd_n, ext_mem_wr_n}, 4'hf);
        for (int i = 0; i < 4; i++) begin
            prev = sys_clk;
            @(posedge mclk);
            chk("sys_clk", sys_clk, !prev);
        end
        $display("t_reset done");
    endtask

    task automatic one_int(input logic [15:0] a, input logic [7:0] blk, input logic [2:0] idx,
                           input logic fn, input logic sp);
        xfer(1'b1, a[8], {4'h0, a});
        chk("int_sel", sel, {blk, idx, fn, sp});
        chk("int flags", flags, a[8] ? 3'b010 : 3'b100);
        chk("int n_busy", n_busy, 2);
        chk("int strobes", low_mask, 4'h0);
    endtask

    task automatic t_internal();
        one_int(16'ha503, BLK_MMU, 3'h1, 1'b1, 1'b0);
        one_int(16'h0106, BLK_MMU, 3'h3, 1'b0, 1'b0);
        one_int(16'hff25, BLK_TMR, 3'h2, 1'b1, 1'b0);
        one_int(16'h0120, BLK_TMR, 3'h0, 1'b0, 1'b0);
        one_int(16'h0028, BLK_UART, IDX_BAUD, 1'b0, 1'b0);
        one_int(16'h012a, BLK_UART, 3'h0, 1'b0, 1'b0);
        one_int(16'h802d, BLK_UART, 3'h1, 1'b1, 1'b0);
        one_int(16'h0133, BLK_CSIO, 3'h1, 1'b1, 1'b0);
        one_int(16'h0030, BLK_CSIO, 3'h0, 1'b0, 1'b0);
        one_int(16'h0139, BLK_PORT, 3'h0, 1'b1, 1'b1);
        one_int(16'h0039, BLK_PORT, 3'h0, 1'b1, 1'b1);
        one_int(16'h7e3f, BLK_PORT, 3'h3, 1'b1, 1'b0);
        one_int(16'h5a1f, BLK_SCR, 3'h4, 1'b0, 1'b0);
        one_int(16'h0317, BLK_DMA, 3'h7, 1'b0, 1'b0);
        one_int(16'hc036, BLK_INTC, 3'h2, 1'b0, 1'b0);
        $display("t_internal done");
    endtask

    task automatic t_reserved();
        logic [7:0] rs [7] = '{8'h08, 8'h0f, 8'h18, 8'h1a, 8'h29, 8'h2e, 8'h2f};
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, i[0], {12'h770, rs[i]});
            chk("rsv flags", flags, 3'b001);
            chk("rsv int_sel", sel, 13'h0000);
            chk("rsv strobes", low_mask, 4'h0);
            chk("rsv_rdata", rsv_rdata, 8'hff);
        end
        $display("t_reserved done");
    endtask

    task automatic t_ext_io();
        int f [4];
        for (int w = 0; w < 4; w++) begin
            cfg({w[1:0], 6'h00}, 1'b0, 1'b0, 2'h0);
            xfer(1'b1, 1'b0, 20'h00080);
            chk("io n_busy", n_busy, 2 * (3 + w));
            chk("io rd strobe", low_mask, 4'h8);
            f[w] = first_low;
        end
        chk("io start", f[1] - f[0], 0);
        chk("io slow start", f[3] - f[0], 1);
        xfer(1'b1, 1'b1, 20'h012ff);
        chk("io wr strobe", low_mask, 4'h4);
        $display("t_ext_io done");
    endtask

    task automatic one_mem(input logic en, input logic rm, input logic [1:0] bk,
                           input logic [7:0] sc, input logic wr, input logic [19:0] a,
                           input logic [6:0] ea, input logic [6:0] msk, input int len,
                           input logic [3:0] stb);
        cfg(sc, en, rm, bk);
        xfer(1'b0, wr, a);
        chk("mem_area", area & msk, ea);
        chk("mem n_busy", n_busy, len);
        chk("mem strobes", low_mask, stb);
    endtask

    task automatic t_mem();
        one_mem(0, 0, 0, 8'h30, 0, 20'h7ffff, 7'h40, 7'h70, 4, 4'h2);
        one_mem(0, 0, 0, 8'h20, 1, 20'h00000, 7'h40, 7'h70, 6, 4'h1);
        one_mem(0, 0, 0, 8'h20, 0, 20'h80000, 7'h20, 7'h70, 4, 4'h2);
        one_mem(0, 0, 0, 8'h00, 0, 20'hfffff, 7'h20, 7'h70, 6, 4'h2);
        one_mem(1, 0, 0, 8'h20, 0, 20'h80000, 7'h10, 7'h7f, 6, 4'h0);
        one_mem(1, 0, 2, 8'h30, 1, 20'hbffff, 7'h1f, 7'h7f, 6, 4'h0);
        one_mem(1, 0, 1, 8'h20, 0, 20'ha5678, 7'h12, 7'h7f, 6, 4'h0);
        one_mem(1, 0, 0, 8'h20, 0, 20'hc0000, 7'h20, 7'h70, 4, 4'h2);
        one_mem(1, 0, 0, 8'h30, 0, 20'h7ffff, 7'h40, 7'h70, 4, 4'h2);
        one_mem(1, 1, 0, 8'h20, 0, 20'hc0000, 7'h10, 7'h7f, 6, 4'h0);
        one_mem(1, 1, 1, 8'h20, 0, 20'hfffff, 7'h13, 7'h7f, 6, 4'h0);
        one_mem(1, 1, 2, 8'h20, 1, 20'hd0000, 7'h1f, 7'h7f, 6, 4'h0);
        one_mem(1, 1, 3, 8'h20, 0, 20'he1234, 7'h1f, 7'h7f, 6, 4'h0);
        $display("t_mem done");
    endtask

    initial begin
        n_errors         = 0;
        n_compared       = 0;
        rst_n            = 1'b0;
        system_control_0 = 8'h00;
        dram_en          = 1'b0;
        dram_top_remap   = 1'b0;
        dram_bank_cfg    = 2'h0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_internal();
        t_reserved();
        t_ext_io();
        t_mem();
        stop_test();
    end
endmodule
